// >>> pkg/gfs_pkg.sv
package gfs_pkg;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned BLK_W      = 128;
  // address map: group in addr[7:4], word in addr[3:2]
  localparam logic [3:0] GRP_CTRL    = 4'h0;
  localparam logic [3:0] GRP_KEY     = 4'h2;
  localparam logic [3:0] GRP_INPUT_DATA_FIELD   = 4'h3;
  localparam logic [3:0] GRP_ODATA   = 4'h4;
  localparam logic [3:0] GRP_IV      = 4'h5;
  localparam logic [3:0] GRP_LEN     = 4'h6;
  localparam logic [3:0] GRP_GHASH   = 4'h7;
  localparam logic [3:0] GRP_HSUB    = 4'h8;
  localparam logic [1:0] IDX_MODE    = 2'h0;
  localparam logic [1:0] IDX_START   = 2'h1;
  localparam logic [1:0] IDX_ISR     = 2'h2;
  localparam logic [1:0] IDX_IMR     = 2'h3;
  localparam logic [1:0] IDX_AUTH_DATA_LENGTH  = 2'h0;
  localparam logic [1:0] IDX_CIPHER_TEXT_LENGTH    = 2'h1;
  localparam logic [1:0] IDX_LAST    = 2'h3;
  // mode register fields
  localparam int unsigned MODE_GCM   = 0;
  localparam int unsigned MODE_DEC   = 1;
  localparam int unsigned MODE_START_METHOD_SELECT  = 2;
  localparam logic [3:0] MODE_RST    = 4'h0;
  localparam logic [1:0] START_METHOD_SELECT_MANUAL = 2'h0;
  localparam logic [1:0] START_METHOD_SELECT_AUTO   = 2'h1;
  localparam int unsigned START_BIT  = 0;
  localparam int unsigned ISR_RDY    = 0;
  localparam logic [31:0] BLK_BYTES  = 32'h0000_0010;
  localparam logic [31:0] CTR_ONE    = 32'h0000_0001;
  // cipher and ghash timing
  localparam logic [3:0] AES_ROUNDS  = 4'hA;
  localparam logic [6:0] GF_LAST     = 7'h7F;
  localparam logic [127:0] GF_POLY   = {8'hE1, 120'h0};
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_KEY  = 2'b01,
    S_CIPH = 2'b10,
    S_HASH = 2'b11
  } gfs_state_t;
endpackage : gfs_pkg

// >>> logic/gfs_aes_core.sv
`timescale 1ns/1ps
// iterative aes-128 encrypt, one round per clock
module gfs_aes_core
  import gfs_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic [127:0] key,
  input  wire logic [127:0] blk,
  output logic              done,
  output logic [127:0]      result
);
  logic [127:0] st_ff;
  logic [127:0] rk_ff;
  logic [7:0]   rcon_ff;
  logic [3:0]   rnd_ff;
  logic         busy_ff;
  logic         done_ff;
  logic [127:0] nxt_st;
  logic [127:0] nxt_rk;
  logic [31:0]  ktmp;
  logic [7:0]   sb [16];
  logic [7:0]   sr [16];
  logic [7:0]   mc [16];
  logic [7:0]   a0, a1, a2, a3;

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction : xt

  function automatic logic [7:0] gm(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction : gm

  // inverse as a^254, then the affine map; area traded for no table
  function automatic logic [7:0] sbox(input logic [7:0] a);
    logic [7:0] s;
    logic [7:0] r;
    s = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      s = gm(s, s);
      r = gm(r, s);
    end
    return r ^ {r[6:0], r[7]} ^ {r[5:0], r[7:6]} ^ {r[4:0], r[7:5]} ^
           {r[3:0], r[7:4]} ^ 8'h63;
  endfunction : sbox

  // one round plus the next round key
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      sb[i] = sbox(st_ff[127-8*i -: 8]);
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        sr[4*c+r] = sb[4*((c+r)%4)+r];
      end
    end
    for (int c = 0; c < 4; c++) begin
      a0 = sr[4*c];
      a1 = sr[4*c+1];
      a2 = sr[4*c+2];
      a3 = sr[4*c+3];
      mc[4*c]   = xt(a0) ^ xt(a1) ^ a1 ^ a2 ^ a3;
      mc[4*c+1] = a0 ^ xt(a1) ^ xt(a2) ^ a2 ^ a3;
      mc[4*c+2] = a0 ^ a1 ^ xt(a2) ^ xt(a3) ^ a3;
      mc[4*c+3] = xt(a0) ^ a0 ^ a1 ^ a2 ^ xt(a3);
    end
    ktmp = {sbox(rk_ff[23:16]), sbox(rk_ff[15:8]), sbox(rk_ff[7:0]),
            sbox(rk_ff[31:24])} ^ {rcon_ff, 24'h000000};
    nxt_rk[127:96] = rk_ff[127:96] ^ ktmp;
    nxt_rk[95:64]  = rk_ff[95:64] ^ nxt_rk[127:96];
    nxt_rk[63:32]  = rk_ff[63:32] ^ nxt_rk[95:64];
    nxt_rk[31:0]   = rk_ff[31:0] ^ nxt_rk[63:32];
    for (int i = 0; i < 16; i++) begin
      nxt_st[127-8*i -: 8] = (rnd_ff == AES_ROUNDS) ? sr[i] : mc[i];
    end
    nxt_st = nxt_st ^ nxt_rk;
  end

  // round sequencing; last round skips the column mix
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff   <= 128'h0;
      rk_ff   <= 128'h0;
      rcon_ff <= 8'h01;
      rnd_ff  <= 4'h1;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (start) begin
      st_ff   <= blk ^ key;
      rk_ff   <= key;
      rcon_ff <= 8'h01;
      rnd_ff  <= 4'h1;
      busy_ff <= 1'b1;
      done_ff <= 1'b0;
    end else if (busy_ff) begin
      st_ff   <= nxt_st;
      rk_ff   <= nxt_rk;
      rcon_ff <= xt(rcon_ff);
      rnd_ff  <= rnd_ff + 4'h1;
      busy_ff <= (rnd_ff != AES_ROUNDS);
      done_ff <= (rnd_ff == AES_ROUNDS);
    end else begin
      done_ff <= 1'b0;
    end
  end

  assign done   = done_ff;
  assign result = st_ff;
endmodule : gfs_aes_core

// >>> logic/gfs_engine.sv
`timescale 1ns/1ps
// Overview of operation
// - key write in gcm mode computes subkey, flags ready
// - subkey readable and overwritable after generation
// - fragment or whole-message lengths both work
// - ready flag raised when input block processed
// - aad blocks update hash only, no output
module gfs_engine
  import gfs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  output logic                   irq
);
  gfs_state_t   state_ff;
  logic [3:0]   mode_ff;
  logic         isr_ff;
  logic         imr_ff;
  logic         irq_ff;
  logic [31:0]  rdata_ff;
  logic [127:0] key_ff;
  logic [127:0] input_data_field_ff;
  logic [127:0] odata_ff;
  logic [127:0] iv_ff;
  logic [127:0] ghash_ff;
  logic [127:0] hsub_ff;
  logic [31:0]  aad_len_ff;
  logic [31:0]  cipher_text_length_ff;
  logic [31:0]  aad_done_ff;
  logic [127:0] hx_ff;
  logic [127:0] hz_ff;
  logic [127:0] hv_ff;
  logic [6:0]   bit_cnt_ff;
  logic         aes_start_ff;
  logic [127:0] nxt_input_data_field;
  logic [127:0] nxt_hz;
  logic [127:0] aes_res;
  logic [31:0]  rd_val;
  logic [3:0]   grp;
  logic [1:0]   idx;
  logic [6:0]   wbase;
  logic         idle;
  logic         aad_phase;
  logic         key_go;
  logic         blk_go;
  logic         aes_done;
  logic         hash_end;
  logic         rdy_set;
  logic         rdy_clr;

  // address split; word 0 is the most significant word of a block
  assign grp       = reg_addr[7:4];
  assign idx       = reg_addr[3:2];
  assign wbase     = {~idx, 5'h00};
  assign idle      = (state_ff == S_IDLE);
  assign aad_phase = (aad_done_ff < aad_len_ff);
  assign hash_end  = (state_ff == S_HASH) && (bit_cnt_ff == GF_LAST);

  // last key word written in gcm mode launches the subkey pass
  assign key_go = idle && reg_wr && (grp == GRP_KEY) && (idx == IDX_LAST) &&
                  mode_ff[MODE_GCM];

  // manual: start bit; auto: last input word written
  always_comb begin
    blk_go = 1'b0;
    if (idle && reg_wr) begin
      if (mode_ff[MODE_START_METHOD_SELECT +: 2] == START_METHOD_SELECT_MANUAL)
        blk_go = (grp == GRP_CTRL) && (idx == IDX_START) && reg_wdata[START_BIT];
      else if (mode_ff[MODE_START_METHOD_SELECT +: 2] == START_METHOD_SELECT_AUTO)
        blk_go = (grp == GRP_INPUT_DATA_FIELD) && (idx == IDX_LAST);
    end
  end

  // input merged with the write in flight, so auto start sees word 3
  always_comb begin
    nxt_input_data_field = input_data_field_ff;
    if (reg_wr && (grp == GRP_INPUT_DATA_FIELD))
      nxt_input_data_field[wbase +: 32] = reg_wdata;
  end

  // one-bit-per-clock gf(2^128) product step, gcm bit order
  assign nxt_hz = hx_ff[127] ? (hz_ff ^ hv_ff) : hz_ff;

  gfs_aes_core u_aes (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (aes_start_ff),
    .key     (key_ff),
    .blk     ((state_ff == S_KEY) ? 128'h0 : iv_ff),
    .done    (aes_done),
    .result  (aes_res)
  );

  // sequencer
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff     <= S_IDLE;
      aes_start_ff <= 1'b0;
    end else begin
      aes_start_ff <= key_go || (blk_go && !aad_phase);
      case (state_ff)
        S_IDLE: begin
          if (key_go)
            state_ff <= S_KEY;
          else if (blk_go)
            state_ff <= aad_phase ? S_HASH : S_CIPH;
        end
        S_KEY: begin
          if (aes_done) state_ff <= S_IDLE;
        end
        S_CIPH: begin
          if (aes_done) state_ff <= S_HASH;
        end
        S_HASH: begin
          if (hash_end) state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // multiplier operands: x shifts out msb first, v walks right
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hx_ff      <= 128'h0;
      hz_ff      <= 128'h0;
      hv_ff      <= 128'h0;
      bit_cnt_ff <= 7'h00;
    end else if (idle && blk_go && aad_phase) begin
      hx_ff      <= ghash_ff ^ nxt_input_data_field;
      hz_ff      <= 128'h0;
      hv_ff      <= hsub_ff;
      bit_cnt_ff <= 7'h00;
    end else if ((state_ff == S_CIPH) && aes_done) begin
      // decrypt hashes the ciphertext that came in, encrypt the one going out
      hx_ff      <= ghash_ff ^ (mode_ff[MODE_DEC] ? input_data_field_ff : (input_data_field_ff ^ aes_res));
      hz_ff      <= 128'h0;
      hv_ff      <= hsub_ff;
      bit_cnt_ff <= 7'h00;
    end else if (state_ff == S_HASH) begin
      hx_ff      <= {hx_ff[126:0], 1'b0};
      hz_ff      <= nxt_hz;
      hv_ff      <= {1'b0, hv_ff[127:1]} ^ (hv_ff[0] ? GF_POLY : 128'h0);
      bit_cnt_ff <= bit_cnt_ff + 7'h01;
    end
  end

  // control registers; key and input data are write-only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_ff  <= MODE_RST;
      imr_ff   <= 1'b0;
      key_ff   <= 128'h0;
      input_data_field_ff <= 128'h0;
    end else begin
      input_data_field_ff <= nxt_input_data_field;
      if (reg_wr && (grp == GRP_CTRL) && (idx == IDX_MODE))
        mode_ff <= reg_wdata[3:0];
      if (reg_wr && (grp == GRP_CTRL) && (idx == IDX_IMR))
        imr_ff <= reg_wdata[ISR_RDY];
      // key held while busy so a round never sees a torn key
      if (idle && reg_wr && (grp == GRP_KEY))
        key_ff[wbase +: 32] <= reg_wdata;
    end
  end

  // output data only from payload blocks
  always_ff @(posedge ref_clk) begin
    if (rst)
      odata_ff <= 128'h0;
    else if ((state_ff == S_CIPH) && aes_done)
      odata_ff <= input_data_field_ff ^ aes_res;
  end

  // hash subkey: filled by the zero-block pass, then free to overwrite
  always_ff @(posedge ref_clk) begin
    if (rst)
      hsub_ff <= 128'h0;
    else if ((state_ff == S_KEY) && aes_done)
      hsub_ff <= aes_res;
    else if (idle && reg_wr && (grp == GRP_HSUB))
      hsub_ff[wbase +: 32] <= reg_wdata;
  end

  // running hash kept until software reloads it
  always_ff @(posedge ref_clk) begin
    if (rst)
      ghash_ff <= 128'h0;
    else if (hash_end)
      ghash_ff <= nxt_hz;
    else if (idle && reg_wr && (grp == GRP_GHASH))
      ghash_ff[wbase +: 32] <= reg_wdata;
  end

  // counter block: only the low word steps, wrapping in 32 bits
  always_ff @(posedge ref_clk) begin
    if (rst)
      iv_ff <= 128'h0;
    else if ((state_ff == S_CIPH) && aes_done)
      iv_ff[31:0] <= iv_ff[31:0] + CTR_ONE;
    else if (idle && reg_wr && (grp == GRP_IV))
      iv_ff[wbase +: 32] <= reg_wdata;
  end

  // lengths; aad progress restarts on an aad length write, so either
  // per-fragment or remaining-message lengths steer the phase alike
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aad_len_ff  <= 32'h0;
      cipher_text_length_ff     <= 32'h0;
      aad_done_ff <= 32'h0;
    end else if (idle && reg_wr && (grp == GRP_LEN) && (idx == IDX_AUTH_DATA_LENGTH)) begin
      aad_len_ff  <= reg_wdata;
      aad_done_ff <= 32'h0;
    end else begin
      if (idle && reg_wr && (grp == GRP_LEN) && (idx == IDX_CIPHER_TEXT_LENGTH))
        cipher_text_length_ff <= reg_wdata;
      if (idle && blk_go && aad_phase)
        aad_done_ff <= aad_done_ff + BLK_BYTES;
    end
  end

  // ready flag: hardware set beats a write-one clear in the same cycle
  assign rdy_set = ((state_ff == S_KEY) && aes_done) || hash_end;
  assign rdy_clr = reg_wr && (grp == GRP_CTRL) && (idx == IDX_ISR) && reg_wdata[ISR_RDY];
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      isr_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      isr_ff <= rdy_set | (isr_ff & ~rdy_clr);
      irq_ff <= (rdy_set | (isr_ff & ~rdy_clr)) & imr_ff;
    end
  end

  // read mux; unmapped words read zero
  always_comb begin
    rd_val = 32'h0;
    case (grp)
      GRP_CTRL: begin
        if (idx == IDX_MODE)     rd_val = {28'h0, mode_ff};
        else if (idx == IDX_ISR) rd_val = {31'h0, isr_ff};
        else if (idx == IDX_IMR) rd_val = {31'h0, imr_ff};
      end
      GRP_ODATA: rd_val = odata_ff[wbase +: 32];
      GRP_IV:    rd_val = iv_ff[wbase +: 32];
      GRP_LEN: begin
        if (idx == IDX_AUTH_DATA_LENGTH)    rd_val = aad_len_ff;
        else if (idx == IDX_CIPHER_TEXT_LENGTH) rd_val = cipher_text_length_ff;
      end
      GRP_GHASH: rd_val = ghash_ff[wbase +: 32];
      GRP_HSUB:  rd_val = hsub_ff[wbase +: 32];
      default:   rd_val = 32'h0;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst)
      rdata_ff <= 32'h0;
    else
      rdata_ff <= reg_rd ? rd_val : 32'h0;
  end

  assign reg_rdata = rdata_ff;
  assign irq       = irq_ff;
endmodule : gfs_engine

// >>> bench/gfs_engine_properties.sv
`timescale 1ns/1ps
// port-level checker; mode and mask are mirrored from bus writes
module gfs_chk
  import gfs_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              irq
);
  logic [3:0] mode_ff;
  logic       mask_ff;
  logic       key_go;
  logic       blk_go;
  // mode mirror, so a start is only judged when it can take effect
  always_ff @(posedge ref_clk) begin
    if (rst) mode_ff <= 4'h0;
    else if (reg_wr && reg_addr == 8'h00) mode_ff <= reg_wdata[3:0];
  end
  // mask mirror
  always_ff @(posedge ref_clk) begin
    if (rst) mask_ff <= 1'b0;
    else if (reg_wr && reg_addr == 8'h0C) mask_ff <= reg_wdata[0];
  end
  // irq low beforehand means status clear, so a rise is the new event
  assign key_go = reg_wr && reg_addr == 8'h2C && mode_ff[0] && mask_ff && !irq;
  assign blk_go = reg_wr && reg_addr == 8'h04 && reg_wdata[0] && mode_ff == 4'h1
                  && mask_ff && !irq;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence quiet_12;
    (!irq)[*8] ##1 (!irq)[*4];
  endsequence
  sequence ready_now;
    irq;
  endsequence
  chk_key_ready: assert property (key_go |=> quiet_12 ##1 ready_now)
    else $error("subkey ready not at cycle 12");
  chk_block_ready: assert property (blk_go |=> (!irq)[*8] ##[100:160] ready_now)
    else $error("block ready out of window");
  chk_irq_masked: assert property (!mask_ff && !$past(mask_ff) |-> !irq)
    else $error("irq while masked");
  // mask_ff gates the antecedent: irq lags a mask-off write by one edge
  chk_irq_sticky: assert property (irq && mask_ff &&
    !(reg_wr && reg_addr inside {8'h08, 8'h0C}) |=> irq)
    else $error("ready dropped without clear");
  chk_mask_off: assert property ((reg_wr && reg_addr == 8'h0C && !reg_wdata[0])
    ##1 !(reg_wr && reg_addr == 8'h0C) |=> !irq)
    else $error("irq kept after mask off");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (reg_rd && reg_addr[7:4] inside {4'h1, 4'h2, 4'h3,
    [4'h9:4'hF]} |=> reg_rdata == 32'h0)
    else $error("write-only or unmapped read not zero");
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && reg_rdata == 32'h0)
    else $error("outputs active in reset");
endmodule : gfs_chk

bind gfs_engine gfs_chk u_chk (
  .ref_clk  (ref_clk),
  .rst      (rst),
  .reg_addr (reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr   (reg_wr),
  .reg_rd   (reg_rd),
  .reg_rdata(reg_rdata),
  .irq      (irq)
);

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import gfs_pkg::*;
  localparam logic [127:0] KEY = 128'h0F0E0D0C_0B0A0908_07060504_03020100;
  localparam logic [127:0] H1  = {8'h80, 120'h0}; // ghash multiply by one
  localparam logic [127:0] IV  = {96'hCAFEBABE_FACEDBAD_DECAF888, 32'h00000002};
  localparam logic [127:0] G0  = 128'h11223344_55667788_99AABBCC_DDEEFF00;
  localparam logic [127:0] AAD = 128'hFEEDFACE_DEADBEEF_FEEDFACE_DEADBEEF;
  localparam logic [127:0] PT  = 128'hD9313225_F88406E5_A55909C5_AFF5269A;
  localparam logic [7:0] RADR [13] = '{8'h00, 8'h08, 8'h0C, 8'h40, 8'h5C, 8'h60, 8'h64,
                                       8'h70, 8'h80, 8'h10, 8'h20, 8'h30, 8'h90};
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq;
  int                errors = 0;
  int                checked = 0;
  int                n;
  logic [127:0]      g, o, o0;
  logic [31:0]       w;

  always #5 ref_clk = ~ref_clk;

  gfs_engine uut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

  task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one-cycle strobes, launched and dropped right after edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata; // data stand only in the slot after the strobe
  endtask : rd
  // word 0 is the most significant
  task automatic wr128(input logic [7:0] a, input logic [127:0] d);
    for (int i = 0; i < 4; i++) wr(a + 8'(4 * i), d[127 - 32 * i -: 32]);
  endtask : wr128
  task automatic rd128(input logic [7:0] a, output logic [127:0] d);
    for (int i = 0; i < 4; i++) rd(a + 8'(4 * i), d[127 - 32 * i -: 32]);
  endtask : rd128
  // bounded wait on the level interrupt, counted from the launching edge
  task automatic wait_rdy(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 400) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    check("ready_wait", irq, 1'b1);
  endtask : wait_rdy
  task automatic final_report;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // watchdog: full run is under a thousand cycles
  initial begin
    #60000;
    errors++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (RADR[i]) begin
      rd(RADR[i], w);
      check("reset_read", w, 32'h0);
    end
    $display("test reset done");
    wr(8'h0C, 32'h1);
    wr(8'h00, 32'h1);
    wr128(8'h20, KEY);
    wait_rdy(n);
    check("subkey_latency", n, 12);
    rd(8'h08, w);
    check("status_ready", w, 32'h1);
    rd128(8'h80, g);
    check("subkey_made", g != 128'h0, 1'b1);
    wr128(8'h80, H1);
    rd128(8'h80, g);
    check("subkey_overwrite", g, H1);
    wr(8'h08, 32'h1);
    #1;
    check("irq_cleared", irq, 1'b0);
    $display("test subkey done");
    wr128(8'h50, IV);
    wr(8'h60, 32'h10);
    wr(8'h64, 32'h10);
    wr128(8'h70, G0);
    rd128(8'h40, o0);
    wr128(8'h30, AAD);
    wr(8'h04, 32'h1);
    wait_rdy(n);
    rd128(8'h70, g);
    check("ghash_aad", g, G0 ^ AAD);
    rd128(8'h40, o);
    check("aad_no_output", o, o0);
    wr(8'h08, 32'h1);
    wr128(8'h30, PT);
    wr(8'h04, 32'h1);
    wait_rdy(n);
    rd128(8'h40, o);
    rd128(8'h70, g);
    check("ghash_enc", g, G0 ^ AAD ^ o);
    rd(8'h5C, w);
    check("counter_enc", w, IV[31:0] + 32'h1);
    $display("test encrypt fragment done");
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h7);
    wr(8'h60, 32'h0);
    wr(8'h64, 32'h20);
    // counter rewound, so decrypting the fresh ciphertext must give the plaintext back
    wr128(8'h50, IV);
    o0 = g;
    wr128(8'h30, o);
    wait_rdy(n);
    rd128(8'h70, g);
    check("ghash_dec_auto", g, o0 ^ o);
    rd128(8'h40, o);
    check("dec_round_trip", o, PT);
    rd(8'h5C, w);
    check("counter_dec", w, IV[31:0] + 32'h1);
    $display("test decrypt auto done");
    wr(8'h0C, 32'h0);
    @(posedge ref_clk);
    #1;
    check("irq_masked", irq, 1'b0);
    rd(8'h08, w);
    check("status_sticky", w, 32'h1);
    wr(8'h0C, 32'h1);
    @(posedge ref_clk);
    #1;
    check("irq_unmasked", irq, 1'b1);
    wr(8'h08, 32'h1);
    @(posedge ref_clk);
    #1;
    check("irq_after_clear", irq, 1'b0);
    rd(8'h08, w);
    check("status_cleared", w, 32'h0);
    $display("test interrupt done");
    final_report();
  end
endmodule : tb_top
